// ---- common/sjt_pkg.sv ----
// Shared constants and types of the boundary scan test port
package sjt_pkg;

  localparam int SJT_IR_W = 3;
  localparam int SJT_ID_W = 32;
  localparam int SJT_BSR_LEN = 109;
  localparam int SJT_TRI_CELL = 108;

  localparam logic [2:0] SJT_IR_EXTEST = 3'h0;
  localparam logic [2:0] SJT_IR_IDCODE = 3'h1;
  localparam logic [2:0] SJT_IR_SAMPLEZ = 3'h2;
  localparam logic [2:0] SJT_IR_SAMPLE = 3'h4;
  localparam logic [2:0] SJT_IR_BYPASS = 3'h7;
  localparam logic [2:0] SJT_IR_CAPTURE = 3'h1;
  localparam logic [2:0] SJT_IR_RESET = SJT_IR_IDCODE;

  localparam logic [2:0] SJT_ID_REVISION = 3'h0;
  // Arbitrary neutral identity values
  localparam logic [16:0] SJT_PART_CODE_DEF = 17'h0A5A5;
  localparam logic [10:0] SJT_MAKER_CODE_DEF = 11'h155;
  localparam logic SJT_ID_PRESENT = 1'h1;

  localparam logic SJT_TRI_RESET = 1'h1;
  localparam logic SJT_BYPASS_CAPTURE = 1'h0;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } sjt_state_t;

  typedef enum logic [1:0] {SEL_BYPASS, SEL_ID, SEL_BSR} sjt_dr_sel_t;

  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
    logic tlr;
  } sjt_dr_ctl_t;

endpackage

// ---- src/sjt_bsr_chain.sv ----
// Boundary scan chain with shift stage and latched update stage
`timescale 1ns/1ns
`default_nettype none
module sjt_bsr_chain
  import sjt_pkg::*;
#(
  parameter int Len = SJT_BSR_LEN
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire sjt_dr_ctl_t ctl,
  input wire logic serialIn,
  input wire logic [Len-2:0] pinSample,
  output logic serialOut,
  output logic [Len-1:0] updateOut
);

  logic [Len-1:0] shift_ff;
  logic [Len-1:0] nxt_shift;
  logic [Len-1:0] upd_ff;
  logic [Len-1:0] nxt_upd;

  always_comb begin
    nxt_shift = shift_ff;
    nxt_upd = upd_ff;
    if (ctl.capture) begin
      // Pin cells snapshot the ring, the internal cell reports its latch [R11] [R15]
      nxt_shift = {upd_ff[Len-1], pinSample};
    end else if (ctl.shift) begin
      // Enter at the top, leave at the bottom; capture data leaves as preload enters [R2] [R18]
      nxt_shift = {serialIn, shift_ff[Len-1:1]};
    end
    if (ctl.tlr) begin
      nxt_upd[Len-1] = SJT_TRI_RESET; // [R21]
    end else if (ctl.update) begin
      nxt_upd = shift_ff; // [R17] [R20]
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shift_ff <= '0;
      upd_ff <= {SJT_TRI_RESET, {(Len-1){1'b0}}}; // [R21]
    end else begin
      shift_ff <= nxt_shift;
      upd_ff <= nxt_upd;
    end
  end

  assign serialOut = shift_ff[0];
  assign updateOut = upd_ff;

endmodule
`default_nettype wire

// ---- src/sjt_tap_top.sv ----
// Boundary scan test access port controller, instruction and data registers
//
// Notes on behaviour
// R1: Test inputs sampled on test clock rise, outputs change on test clock fall.
// R2: Selected register shifts in at its top bit, out from its bottom bit.
// R3: Five rising edges with mode select high reset the port, memory unaffected.
// R4: Power-up reset leaves serial data-out in high impedance.
// R5: Exactly one register sits in the serial path, chosen by the instruction.
// R6: Three-bit instruction register holds identification after reset and Test-Logic-Reset.
// R7: Capture-IR loads 01 into the two lowest instruction bits.
// R8: Instructions shift in Shift-IR and take effect only at Update-IR.
// R9: Bypass is one flip-flop, captured low under the bypass instruction.
// R10: Bypass instruction puts the bypass bit in the Shift-DR path.
// R11: Capture-DR loads pin states into the boundary chain; Shift-DR shifts it.
// R12: Identification instruction captures the fixed 32-bit code and shifts it out.
// R13: The controller never loads the three reserved instruction codes; here Update-IR loads them and they select bypass.
// R14: Sample-high-impedance selects the chain and floats the output bus until Update-IR.
// R15: Sample/preload snapshots all pins in Capture-DR without touching memory operation.
// R16: Test clock stays at or below 20 MHz; pins held stable around capture.
// R17: Preload latches a chosen pattern into the parallel update stage.
// R18: Sample data shifts out while preload data shifts in, same pass.
// R19: External test drives update-stage values onto pins and selects the chain.
// R20: Latched cell 108 enables (high) or floats (low) the output bus under external test.
// R21: Cell 108 latch is forced high at power-up and in Test-Logic-Reset.
// R22: Codes: 000 extest, 001 id, 010 sample-Z, 100 sample, 111 bypass.
// R23: Identification word: revision 31:29, part 28:12, maker 11:1, bit 0 one.
// R24: Boundary chain is 109 cells, the last one internal.
// R25: Standard sixteen-state controller advances on each test clock rise by mode select.
// R26: Data-out drives only in Shift-IR and Shift-DR, else high impedance.
`timescale 1ns/1ns
`default_nettype none
module sjt_tap_top
  import sjt_pkg::*;
#(
  parameter int BsrLen = SJT_BSR_LEN, // [R24]
  parameter logic [16:0] PartCode = SJT_PART_CODE_DEF,
  parameter logic [10:0] MakerCode = SJT_MAKER_CODE_DEF
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tckPin,
  input wire logic tmsPin,
  input wire logic tdiPin,
  input wire logic [BsrLen-2:0] pinState,
  output logic tdoOut,
  output logic tdoOe_n,
  output logic qBusHighZ,
  output logic extestDrive,
  output logic [BsrLen-2:0] pinDrive,
  output logic tapInReset
);

  // Data register selected by an instruction; reserved codes fall back to bypass
  function automatic sjt_dr_sel_t drSel(input logic [SJT_IR_W-1:0] code);
    sjt_dr_sel_t sel;
    sel = SEL_BYPASS;
    case (code)
      SJT_IR_IDCODE: sel = SEL_ID; // [R22]
      SJT_IR_EXTEST, SJT_IR_SAMPLEZ, SJT_IR_SAMPLE: sel = SEL_BSR; // [R22]
      default: sel = SEL_BYPASS;
    endcase
    return sel;
  endfunction

  // Pin synchronisers, two flops each
  logic [2:0] pinMeta_ff;
  logic [2:0] pinSync_ff;
  logic tckPrev_ff;
  logic [2:0] nxt_pinMeta;
  logic [2:0] nxt_pinSync;
  logic nxt_tckPrev;
  logic tckRise;
  logic tckFall;
  logic tmsS;
  logic tdiS;

  always_comb begin
    nxt_pinMeta = {tckPin, tmsPin, tdiPin};
    nxt_pinSync = pinMeta_ff;
    nxt_tckPrev = pinSync_ff[2];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
      tckPrev_ff <= 1'b0;
    end else begin
      pinMeta_ff <= nxt_pinMeta;
      pinSync_ff <= nxt_pinSync;
      tckPrev_ff <= nxt_tckPrev;
    end
  end

  assign tckRise = pinSync_ff[2] & ~tckPrev_ff; // [R1]
  assign tckFall = ~pinSync_ff[2] & tckPrev_ff; // [R1]
  assign tmsS = pinSync_ff[1];
  assign tdiS = pinSync_ff[0];

  // Controller state machine
  sjt_state_t state_ff;
  sjt_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (tckRise) begin // [R25]
      case (state_ff)
        ST_TLR: nxt_state = tmsS ? ST_TLR : ST_RTI;
        ST_RTI: nxt_state = tmsS ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: nxt_state = tmsS ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: nxt_state = tmsS ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: nxt_state = tmsS ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR: nxt_state = tmsS ? ST_UPD_DR : ST_PAUSE_DR;
        ST_PAUSE_DR: nxt_state = tmsS ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR: nxt_state = tmsS ? ST_UPD_DR : ST_SHIFT_DR;
        ST_UPD_DR: nxt_state = tmsS ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: nxt_state = tmsS ? ST_TLR : ST_CAP_IR; // [R3]
        ST_CAP_IR: nxt_state = tmsS ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR: nxt_state = tmsS ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR: nxt_state = tmsS ? ST_UPD_IR : ST_PAUSE_IR;
        ST_PAUSE_IR: nxt_state = tmsS ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR: nxt_state = tmsS ? ST_UPD_IR : ST_SHIFT_IR;
        ST_UPD_IR: nxt_state = tmsS ? ST_SEL_DR : ST_RTI;
        default: nxt_state = ST_TLR;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= ST_TLR; // [R4]
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Instruction register
  logic [SJT_IR_W-1:0] irShift_ff;
  logic [SJT_IR_W-1:0] instr_ff;
  logic [SJT_IR_W-1:0] nxt_irShift;
  logic [SJT_IR_W-1:0] nxt_instr;
  sjt_dr_sel_t curSel;

  assign curSel = drSel(instr_ff); // [R5]

  always_comb begin
    nxt_irShift = irShift_ff;
    nxt_instr = instr_ff;
    if (tckRise && state_ff == ST_CAP_IR) begin
      nxt_irShift = SJT_IR_CAPTURE; // [R7]
    end else if (tckRise && state_ff == ST_SHIFT_IR) begin
      nxt_irShift = {tdiS, irShift_ff[SJT_IR_W-1:1]}; // [R2] [R8]
    end
    if (state_ff == ST_TLR) begin
      nxt_instr = SJT_IR_RESET; // [R6]
    end else if (tckFall && state_ff == ST_UPD_IR) begin
      nxt_instr = irShift_ff; // [R8]
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irShift_ff <= SJT_IR_CAPTURE;
      instr_ff <= SJT_IR_RESET; // [R6]
    end else begin
      irShift_ff <= nxt_irShift;
      instr_ff <= nxt_instr;
    end
  end

  // Bypass and identification registers
  logic bypass_ff;
  logic [SJT_ID_W-1:0] idShift_ff;
  logic nxt_bypass;
  logic [SJT_ID_W-1:0] nxt_idShift;
  logic capDr;
  logic shDr;
  logic [SJT_ID_W-1:0] idWord;

  assign idWord = {SJT_ID_REVISION, PartCode, MakerCode, SJT_ID_PRESENT}; // [R23]
  assign capDr = tckRise && state_ff == ST_CAP_DR;
  assign shDr = tckRise && state_ff == ST_SHIFT_DR;

  always_comb begin
    nxt_bypass = bypass_ff;
    nxt_idShift = idShift_ff;
    if (curSel == SEL_BYPASS) begin
      if (capDr) begin
        nxt_bypass = SJT_BYPASS_CAPTURE; // [R9]
      end else if (shDr) begin
        nxt_bypass = tdiS; // [R10]
      end
    end
    if (curSel == SEL_ID) begin
      if (capDr) begin
        nxt_idShift = idWord; // [R12]
      end else if (shDr) begin
        nxt_idShift = {tdiS, idShift_ff[SJT_ID_W-1:1]}; // [R2] [R12]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bypass_ff <= SJT_BYPASS_CAPTURE;
      idShift_ff <= '0;
    end else begin
      bypass_ff <= nxt_bypass;
      idShift_ff <= nxt_idShift;
    end
  end

  // Boundary scan chain
  sjt_dr_ctl_t bsrCtl;
  logic bsrOut;
  logic [BsrLen-1:0] bsrUpd;

  always_comb begin
    bsrCtl.capture = capDr && curSel == SEL_BSR; // [R11] [R15]
    bsrCtl.shift = shDr && curSel == SEL_BSR; // [R14] [R19]
    bsrCtl.update = tckFall && state_ff == ST_UPD_DR && curSel == SEL_BSR; // [R17]
    bsrCtl.tlr = state_ff == ST_TLR; // [R21]
  end

  sjt_bsr_chain #(
    .Len(BsrLen)
  ) u_bsr (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ctl(bsrCtl),
    .serialIn(tdiS),
    .pinSample(pinState),
    .serialOut(bsrOut),
    .updateOut(bsrUpd)
  );

  // Serial output, updated on the test clock fall; pin controls follow the instruction, latch and state
  logic tdo_ff;
  logic tdoOe_n_ff;
  logic qBusHighZ_ff;
  logic extestDrive_ff;
  logic [BsrLen-2:0] pinDrive_ff;
  logic tapInReset_ff;
  logic nxt_tdo;
  logic nxt_tdoOe_n;
  logic nxt_qBusHighZ;
  logic nxt_extestDrive;
  logic [BsrLen-2:0] nxt_pinDrive;
  logic nxt_tapInReset;
  logic srcBit;

  always_comb begin
    case (curSel)
      SEL_ID: srcBit = idShift_ff[0];
      SEL_BSR: srcBit = bsrOut;
      default: srcBit = bypass_ff;
    endcase
  end

  always_comb begin
    nxt_tdo = tdo_ff;
    nxt_tdoOe_n = tdoOe_n_ff;
    if (tckFall) begin // [R1]
      if (state_ff == ST_SHIFT_IR) begin
        nxt_tdo = irShift_ff[0]; // [R2]
        nxt_tdoOe_n = 1'b0; // [R26]
      end else if (state_ff == ST_SHIFT_DR) begin
        nxt_tdo = srcBit; // [R5]
        nxt_tdoOe_n = 1'b0; // [R26]
      end else begin
        nxt_tdoOe_n = 1'b1; // [R26]
      end
    end
    // Instruction and latch change on a fall or on entry to Test-Logic-Reset, so these follow them
    nxt_extestDrive = instr_ff == SJT_IR_EXTEST; // [R19]
    nxt_qBusHighZ = (instr_ff == SJT_IR_SAMPLEZ) ||
                    (instr_ff == SJT_IR_EXTEST && !bsrUpd[SJT_TRI_CELL]); // [R14] [R20]
    nxt_pinDrive = bsrUpd[BsrLen-2:0]; // [R19]
    nxt_tapInReset = state_ff == ST_TLR;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tdo_ff <= 1'b0;
      tdoOe_n_ff <= 1'b1; // [R4]
      qBusHighZ_ff <= 1'b0;
      extestDrive_ff <= 1'b0;
      pinDrive_ff <= '0;
      tapInReset_ff <= 1'b1;
    end else begin
      tdo_ff <= nxt_tdo;
      tdoOe_n_ff <= nxt_tdoOe_n;
      qBusHighZ_ff <= nxt_qBusHighZ;
      extestDrive_ff <= nxt_extestDrive;
      pinDrive_ff <= nxt_pinDrive;
      tapInReset_ff <= nxt_tapInReset;
    end
  end

  assign tdoOut = tdo_ff;
  assign tdoOe_n = tdoOe_n_ff;
  assign qBusHighZ = qBusHighZ_ff;
  assign extestDrive = extestDrive_ff;
  assign pinDrive = pinDrive_ff;
  assign tapInReset = tapInReset_ff;

endmodule
`default_nettype wire

// ---- tb/sjt_jtag_host.sv ----
// Scan controller model driving the test port pins
`timescale 1ns/1ns
`default_nettype none
module sjt_jtag_host (
  input wire logic mclk,
  input wire logic tdoOut,
  input wire logic tdoOe_n,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end
  // One tck cycle of 8 mclk, 400 ns; tdo taken just before the next fall
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    tck <= 1'h0;
    repeat (4) @(posedge mclk);
    tck <= 1'h1;
    repeat (4) @(posedge mclk);
    q = tdoOe_n ? 1'hx : tdoOut;
  endtask
  // From idle: shift n bits LSB first, then update and return to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic q;
    dout = '0;
    step(1'h1, 1'h0, q);
    if (ir) step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
    step(1'h0, 1'h0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask
endmodule
`default_nettype wire

// ---- tb/sjt_tap_props.sv ----
// Port-level assertions of the boundary scan test port
`timescale 1ns/1ns
`default_nettype none
module sjt_tap_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tckPin,
  input wire logic tmsPin,
  input wire logic tdoOut,
  input wire logic tdoOe_n,
  input wire logic qBusHighZ,
  input wire logic extestDrive,
  input wire logic tapInReset
);
  logic [2:0] tckS_ff, nxt_tckS;
  logic [1:0] tmsS_ff, nxt_tmsS;
  logic [2:0] hiCnt_ff, nxt_hiCnt;
  // Own copy of the pin synchronisers; counts rises with mode select high
  always_comb begin
    nxt_tckS = {tckS_ff[1:0], tckPin};
    nxt_tmsS = {tmsS_ff[0], tmsPin};
    nxt_hiCnt = hiCnt_ff;
    if (tckS_ff[1] && !tckS_ff[2]) begin
      nxt_hiCnt = !tmsS_ff[1] ? 3'h0 : (hiCnt_ff == 3'h5) ? 3'h5 : hiCnt_ff + 3'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tckS_ff <= 3'h0;
      tmsS_ff <= 2'h0;
      hiCnt_ff <= 3'h0;
    end else begin
      tckS_ff <= nxt_tckS;
      tmsS_ff <= nxt_tmsS;
      hiCnt_ff <= nxt_hiCnt;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_tdoEdge;
    ($changed(tdoOut) || $changed(tdoOe_n)) |-> !tckPin && !$past(tckPin, 2);
  endproperty
  a_tdoEdge: assert property (p_tdoEdge) else $error("tdo moved outside tck low");
  property p_tmsRst;
    hiCnt_ff == 3'h5 |-> ##[0:2] tapInReset;
  endproperty
  a_tmsRst: assert property (p_tmsRst) else $error("five tms highs gave no reset");
  property p_rstOut;
    $fell(sys_rst) |-> tdoOe_n && tapInReset;
  endproperty
  a_rstOut: assert property (p_rstOut) else $error("tdo driven after reset");
  property p_rstBus;
    $fell(sys_rst) |-> !qBusHighZ && !extestDrive;
  endproperty
  a_rstBus: assert property (p_rstBus) else $error("bus not released after reset");
  property p_tlrIdle;
    tapInReset [*3] |-> !extestDrive && !qBusHighZ;
  endproperty
  a_tlrIdle: assert property (p_tlrIdle) else $error("test mode active in reset state");
  property p_tlrOe;
    tapInReset |-> tdoOe_n;
  endproperty
  a_tlrOe: assert property (p_tlrOe) else $error("tdo driven in reset state");
  property p_oeHold;
    $fell(tdoOe_n) |-> !tdoOe_n [*6];
  endproperty
  a_oeHold: assert property (p_oeHold) else $error("tdo drive shorter than a tck cycle");
  property p_stateEdge;
    $changed(tapInReset) |-> $past(tckPin, 4) && !$past(tckPin, 5);
  endproperty
  a_stateEdge: assert property (p_stateEdge) else $error("state moved off tck rise");
  c_tmsRst: cover property (hiCnt_ff == 3'h5);
  c_extestZ: cover property (extestDrive && qBusHighZ);
  c_sampleZ: cover property (qBusHighZ && !extestDrive);
endmodule
bind sjt_tap_top sjt_tap_props u_props (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .tckPin(tckPin),
  .tmsPin(tmsPin),
  .tdoOut(tdoOut),
  .tdoOe_n(tdoOe_n),
  .qBusHighZ(qBusHighZ),
  .extestDrive(extestDrive),
  .tapInReset(tapInReset)
);
`default_nettype wire

// ---- tb/sjt_tap_top_tb_top.sv ----
// Self-checking bench of the boundary scan test port
`timescale 1ns/1ns
`default_nettype none
module sjt_tap_top_tb_top;
  import sjt_pkg::*;
  localparam logic [107:0] PINS = {27{4'hA}};
  localparam logic [108:0] PRE = {1'h0, {27{4'h6}}};
  localparam logic [31:0] IDW = {SJT_ID_REVISION, SJT_PART_CODE_DEF, SJT_MAKER_CODE_DEF,
                                 SJT_ID_PRESENT};
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic tck, tms, tdi, tdoOut, tdoOe_n, qBusHighZ, extestDrive, tapInReset, q;
  logic [107:0] pinState = PINS;
  logic [107:0] pinDrive;
  logic [127:0] d;
  int n_errors = 0;
  int tests_run = 0;
  initial begin
    forever #25 mclk = ~mclk;
  end
  sjt_jtag_host u_host (.mclk(mclk), .tdoOut(tdoOut), .tdoOe_n(tdoOe_n), .tck(tck),
                        .tms(tms), .tdi(tdi));
  sjt_tap_top dut (.mclk(mclk), .sys_rst(sys_rst), .tckPin(tck), .tmsPin(tms), .tdiPin(tdi),
                   .pinState(pinState), .tdoOut(tdoOut), .tdoOe_n(tdoOe_n),
                   .qBusHighZ(qBusHighZ), .extestDrive(extestDrive), .pinDrive(pinDrive),
                   .tapInReset(tapInReset));
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic ir(input logic [2:0] c);
    u_host.scan(1'h1, 3, {125'h0, c}, d);
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'h0;
    repeat (4) @(posedge mclk);
    chk("oe", 1'h1, tdoOe_n);
    chk("tlr", 1'h1, tapInReset);
    u_host.step(1'h0, 1'h0, q);
    u_host.scan(1'h0, 32, '0, d);
    chk("idcode", IDW, d[31:0]);
    ir(SJT_IR_BYPASS);
    chk("ircap", 3'h1, d[2:0]);
    u_host.scan(1'h0, 4, 128'hB, d);
    chk("bypass", 4'h6, d[3:0]);
    ir(SJT_IR_SAMPLE);
    u_host.scan(1'h0, 109, {19'h0, PRE}, d);
    chk("sample", {1'h1, PINS}, d[108:0]);
    chk("noext", 1'h0, extestDrive);
    ir(SJT_IR_EXTEST);
    chk("extest", 1'h1, extestDrive);
    chk("cellz", 1'h1, qBusHighZ);
    chk("preload", PRE[107:0], pinDrive);
    u_host.scan(1'h0, 109, {19'h0, 1'h1, 108'h0}, d);
    chk("excap", {1'h0, PINS}, d[108:0]);
    chk("cellon", 1'h0, qBusHighZ);
    chk("exdrv", 108'h0, pinDrive);
    ir(SJT_IR_SAMPLE);
    u_host.scan(1'h0, 109, {19'h0, PRE}, d);
    ir(SJT_IR_EXTEST);
    repeat (5) u_host.step(1'h1, 1'h0, q);
    chk("tmsrst", 1'h1, tapInReset);
    chk("rstext", 1'h0, extestDrive);
    u_host.step(1'h0, 1'h0, q);
    u_host.scan(1'h0, 32, '0, d);
    chk("idagain", IDW, d[31:0]);
    ir(SJT_IR_EXTEST);
    chk("cellset", 1'h0, qBusHighZ);
    ir(SJT_IR_SAMPLEZ);
    chk("samplez", 1'h1, qBusHighZ);
    chk("zext", 1'h0, extestDrive);
    conclude();
  end
endmodule
`default_nettype wire
